// file: bench/scc_clock_ctrl_monitor.sv
// Port assertions for the synthesizer clock control.
`timescale 1ns/100ps
module scc_clock_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_req,
  input wire logic test_mode,
  input wire logic bus_clock_source_sel,
  input wire logic clock_select_out,
  input wire logic cpu_clock_stall,
  input wire logic synth_enable,
  input wire logic low_bw_drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_low_drive: assert property ($fell(low_bw_drive) |-> $past(test_mode, 2))
    else $error("low driver off in user mode");
  a_stall_low: assert property (cpu_clock_stall |-> !clock_select_out)
    else $error("select high in switch");
  a_sel_synth: assert property (clock_select_out |-> bus_clock_source_sel)
    else $error("select high on crystal");
  a_switch_bound: assert property ($rose(cpu_clock_stall) |-> ##[1:200] !cpu_clock_stall)
    else $error("switch too long");
  a_src_power: assert property ($rose(bus_clock_source_sel) |-> synth_enable)
    else $error("source set while off");
  a_stop_off: assert property (stop_req |-> ##[1:2] !synth_enable)
    else $error("synth on in stop");
  c_switch: cover property ($rose(cpu_clock_stall));
  c_err: cover property (pslverr);
  c_stop: cover property ($fell(synth_enable));
endmodule // scc_clock_ctrl_monitor

// file: bench/scc_xtal_model.sv
// Crystal reference and synthesizer output clock seen by the control block.
`timescale 1ns/100ps
module scc_xtal_model #(
  parameter real XH = 75.0,
  parameter real SH = 40.0
) (
  input wire logic synth_enable,
  output logic crystal_input,
  output logic synth_output_clock
);
  initial crystal_input = 1'h0;
  always #(XH) crystal_input = ~crystal_input;
  initial synth_output_clock = 1'h0;
  // A powered-down loop gives no edges, so a switch cannot wait on stale ones.
  always #(SH) synth_output_clock = synth_enable ? ~synth_output_clock : 1'h0;
endmodule // scc_xtal_model

// file: bench/testbench.sv
// Self-checking bench for the synthesizer clock control.
`timescale 1ns/100ps
`include "scc_params.svh"
module testbench;
  localparam int SETTLE = 20;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic test_mode = '0, stop_req = '0, stop_exit = '0, stop_exit_irq = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic pready, pslverr, er, crystal_input, synth_output_clock, synth_fb_clk;
  logic bus_clock_source_sel, clock_select_out, cpu_clock_stall;
  logic synth_enable, low_bw_drive, high_bw_drive;
  logic [1:0] synth_speed_sel;
  int fail_count = 0, total_checks = 0, i, n;
  // Write value beside the value the register must read back.
  // No row picks speed 11, and rows written with the source set pick speed 10 or 01.
  logic [15:0] rows [12] = '{16'h3232, 16'h3030, 16'h3232, 16'h7171, 16'h3D31, 16'h2131,
    16'h1111, 16'h9212, 16'h3131, 16'hF1F1, 16'h91B1, 16'h3131};
  always #12.5 pclk = ~pclk;
  scc_xtal_model u_xtal (.*);
  scc_clock_ctrl dut (.*);
  task test_done;
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // Upper data bits are all ones so that a leak into the register shows.
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'hFFFFFF, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      test_done;
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task wsel(input logic v);
    for (n = 0; clock_select_out !== v; n++) begin
      if (n > 500) begin
        fail_count++;
        test_done;
      end
      @(posedge pclk);
    end
  endtask
  task rd;
    apb(1'h0, `SCC_CTRL_ADDR, 8'h00);
  endtask
  // One full feedback period in synthesizer rises; the first period after a tap change is skipped.
  task fb_span(input int x);
    int k, c, rises;
    logic sp, fp;
    c = 0;
    rises = 0;
    sp = 1'h1;
    fp = 1'h1;
    for (k = 0; k < 2000 && rises < 3; k++) begin
      @(posedge pclk);
      if (synth_output_clock && !sp && rises == 2) c++;
      if (synth_fb_clk && !fp) rises++;
      sp = synth_output_clock;
      fp = synth_fb_clk;
    end
    chk(c, x);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (i = 0; i < 12; i++) begin
      if (rows[i][15]) repeat (SETTLE) @(posedge pclk);
      apb(1'h1, `SCC_CTRL_ADDR, rows[i][15:8]);
      rd;
      chk(rv, {24'h0, rows[i][7:0]});
      chk({high_bw_drive, synth_enable, synth_speed_sel}, {rows[i][6:5], rows[i][1:0]});
    end
    repeat (SETTLE) @(posedge pclk);
    apb(1'h1, `SCC_CTRL_ADDR, 8'hB1);
    wsel(1'h1);
    chk(bus_clock_source_sel, 1'h1);
    apb(1'h0, `SCC_STAT_ADDR, 8'h00);
    chk(rv, 32'h1);
    apb(1'h1, `SCC_CTRL_ADDR, 8'h31);
    apb(1'h1, `SCC_CTRL_ADDR, 8'h72);
    repeat (SETTLE) @(posedge pclk);
    apb(1'h1, `SCC_CTRL_ADDR, 8'hF2);
    wsel(1'h1);
    for (i = 0; i < 2; i++) begin
      stop_req <= 1'h1;
      @(posedge pclk);
      stop_req <= 1'h0;
      wsel(1'h0);
      repeat (4) @(posedge pclk);
      chk(synth_enable, 1'h0);
      stop_exit <= 1'h1;
      stop_exit_irq <= (i == 0);
      @(posedge pclk);
      stop_exit <= 1'h0;
      repeat (4) @(posedge pclk);
      rd;
      chk(rv, i ? 32'h31 : 32'h72);
    end
    apb(1'h0, 12'h008, 8'h00);
    chk(er, 1'h1);
    test_mode <= 1'h1;
    apb(1'h1, `SCC_CTRL_ADDR, 8'h21);
    rd;
    chk(rv, 32'h21);
    test_mode <= 1'h0;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd;
    chk(rv, 32'h31);
    chk({bus_clock_source_sel, high_bw_drive, synth_enable, low_bw_drive}, 4'h3);
    apb(1'h1, `SCC_STAT_ADDR, 8'h00);
    rd;
    chk(rv, 32'h31);
    apb(1'h1, `SCC_CTRL_ADDR, 8'h32);
    fb_span(64);
    test_done;
  end
endmodule // testbench
bind scc_clock_ctrl scc_clock_ctrl_monitor u_mon (.*);

// file: common/scc_params.svh
// Offsets, field positions, reset values and timing counts of the synthesizer clock control.
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
`define SCC_CTRL_ADDR 12'h000
`define SCC_STAT_ADDR 12'h004
`define SCC_BIT_SRC 7
`define SCC_BIT_BWH 6
`define SCC_BIT_PON 5
`define SCC_BIT_VTI 4
`define SCC_BIT_SP1 1
`define SCC_BIT_SP0 0
`define SCC_CTRL_RESET 8'h31
`define SCC_CTRL_WMASK 8'hF3
`define SCC_SPEED_RESET 2'h1
`define SCC_SWITCH_HALF_CYCLES 3
`endif

// file: common/scc_pkg.sv
// Types shared by the synthesizer clock control design files.
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_SW_IDLE,
    SCC_SW_XTAL,
    SCC_SW_SYNTH
  } scc_sw_state_e;
  typedef logic [7:0] scc_ctrl_t;
endpackage

// file: rtl/scc_clock_ctrl.sv
// Synthesizer control register, interlocks, clock source switch and stop handling.
//
// Behaviour
// - Source bit picks synthesizer or crystal half.
// - Switch stalls clocks, select low, bounded time.
// - Source set ignored unless power already on.
// - Low driver on unless filter isolated; bit adds high.
// - Source set allowed while high bandwidth set.
// - Power bit runs synthesizer, not clock path.
// - Power clear refused unless source already clear.
// - Test isolate clearable only in test modes.
// - Speed select picks one of four taps.
// - Reset values: source, bandwidth, speed bit 1 zero; others set.
// - Stop selects crystal rate, powers synthesizer down.
// - Interrupt stop exit keeps config but source, else reset.
// - Feedback divides by 256, 128, 64, 32.
`timescale 1ns/100ps
`include "scc_params.svh"
module scc_clock_ctrl
  import scc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_input,
  input wire logic synth_output_clock,
  input wire logic test_mode,
  input wire logic stop_req,
  input wire logic stop_exit,
  input wire logic stop_exit_irq,
  output logic bus_clock_source_sel,
  output logic clock_select_out,
  output logic cpu_clock_stall,
  output logic synth_enable,
  output logic low_bw_drive,
  output logic high_bw_drive,
  output logic [1:0] synth_speed_sel,
  output logic synth_fb_clk
);
  scc_ctrl_t ctrl;
  scc_ctrl_t next_ctrl;
  scc_ctrl_t saved_ctrl;
  scc_sw_state_e sw_state;
  logic in_stop;
  logic xtal_s;
  logic synth_s;
  logic xtal_d;
  logic synth_d;
  logic [1:0] edge_cnt;
  logic applied_src;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic xtal_edge;
  logic synth_edge;

  scc_sync u_sync_xtal (
    .pclk(pclk),
    .presetn(presetn),
    .d(crystal_input),
    .q(xtal_s)
  );

  scc_sync u_sync_synth (
    .pclk(pclk),
    .presetn(presetn),
    .d(synth_output_clock),
    .q(synth_s)
  );

  assign addr_ok = (paddr == ADDR_W'(`SCC_CTRL_ADDR)) || (paddr == ADDR_W'(`SCC_STAT_ADDR));
  assign wr_en = psel && penable && pwrite && (paddr == ADDR_W'(`SCC_CTRL_ADDR));
  assign rd_en = psel && !penable && !pwrite;
  assign xtal_edge = xtal_s != xtal_d;
  assign synth_edge = synth_s != synth_d;

  // Source and power interlocks act on the value already held; a refused isolate clear sets the bit.
  always_comb begin
    next_ctrl = (ctrl & ~`SCC_CTRL_WMASK) | (pwdata[7:0] & `SCC_CTRL_WMASK);
    if (next_ctrl[`SCC_BIT_SRC] && !ctrl[`SCC_BIT_PON]) begin
      next_ctrl[`SCC_BIT_SRC] = 1'b0;
    end
    if (!next_ctrl[`SCC_BIT_PON] && ctrl[`SCC_BIT_SRC]) begin
      next_ctrl[`SCC_BIT_PON] = 1'b1;
    end
    if (!next_ctrl[`SCC_BIT_VTI] && !test_mode) begin
      next_ctrl[`SCC_BIT_VTI] = 1'b1;
    end
  end

  // The bandwidth bit never gates the source bit; that ordering is software's job.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SCC_CTRL_RESET;
    end else if (stop_req && !in_stop) begin
      ctrl[`SCC_BIT_SRC] <= 1'b0;
    end else if (in_stop && stop_exit) begin
      if (stop_exit_irq) begin
        ctrl <= saved_ctrl & ~(8'h01 << `SCC_BIT_SRC);
      end else begin
        ctrl <= `SCC_CTRL_RESET;
      end
    end else if (wr_en && !in_stop) begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_stop <= 1'b0;
    end else if (stop_req && !in_stop) begin
      in_stop <= 1'b1;
    end else if (in_stop && stop_exit) begin
      in_stop <= 1'b0;
    end
  end

  // The copy is taken before stop entry clears the source bit in the live register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_ctrl <= `SCC_CTRL_RESET;
    end else if (stop_req && !in_stop) begin
      saved_ctrl <= ctrl;
    end
  end

  // The switch waits for crystal edges, then synthesizer edges while it runs; three half-cycles each bound it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_d <= 1'b0;
    end else begin
      xtal_d <= xtal_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_d <= 1'b0;
    end else begin
      synth_d <= synth_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state <= SCC_SW_IDLE;
      edge_cnt <= 2'h0;
      applied_src <= 1'b0;
    end else begin
      case (sw_state)
        SCC_SW_IDLE: begin
          if (ctrl[`SCC_BIT_SRC] != applied_src) begin
            sw_state <= SCC_SW_XTAL;
            edge_cnt <= 2'h0;
          end
        end
        SCC_SW_XTAL: begin
          if (xtal_edge) begin
            if (edge_cnt == 2'(`SCC_SWITCH_HALF_CYCLES - 1)) begin
              sw_state <= SCC_SW_SYNTH;
              edge_cnt <= 2'h0;
            end else begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        SCC_SW_SYNTH: begin
          // A stopped synthesizer gives no edges, so only wait while it runs.
          if (!ctrl[`SCC_BIT_PON] || in_stop || synth_edge) begin
            if (!ctrl[`SCC_BIT_PON] || in_stop ||
                edge_cnt == 2'(`SCC_SWITCH_HALF_CYCLES - 1)) begin
              sw_state <= SCC_SW_IDLE;
              applied_src <= ctrl[`SCC_BIT_SRC];
            end else begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        default: begin
          sw_state <= SCC_SW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_clock_source_sel <= 1'b0;
    end else begin
      bus_clock_source_sel <= applied_src;
    end
  end

  // A pending change drops the select on the same edge that the switch machine leaves idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_select_out <= 1'b0;
    end else begin
      clock_select_out <= (sw_state == SCC_SW_IDLE) && applied_src &&
                          (ctrl[`SCC_BIT_SRC] == applied_src);
    end
  end

  // Stall starts with the register change so no cycle runs on a half-switched clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_stall <= 1'b0;
    end else begin
      cpu_clock_stall <= (sw_state != SCC_SW_IDLE) ||
                         (ctrl[`SCC_BIT_SRC] != applied_src);
    end
  end

  // Stop powers the loop down without touching the power bit, so an irq exit can resume.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_enable <= 1'b1;
    end else begin
      synth_enable <= ctrl[`SCC_BIT_PON] && !in_stop;
    end
  end

  // With the filter isolated for test, neither loop driver is enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_bw_drive <= 1'b1;
      high_bw_drive <= 1'b0;
    end else begin
      low_bw_drive <= ctrl[`SCC_BIT_VTI];
      high_bw_drive <= ctrl[`SCC_BIT_VTI] && ctrl[`SCC_BIT_BWH];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_speed_sel <= `SCC_SPEED_RESET;
    end else begin
      synth_speed_sel <= ctrl[`SCC_BIT_SP1:`SCC_BIT_SP0];
    end
  end

  scc_fb_div #(
    .WIDTH(8)
  ) u_fb_div (
    .pclk(pclk),
    .presetn(presetn),
    .vco_tick(synth_s && !synth_d),
    .run(ctrl[`SCC_BIT_PON] && !in_stop),
    .speed_sel(ctrl[`SCC_BIT_SP1:`SCC_BIT_SP0]),
    .fb_clk(synth_fb_clk)
  );

  // APB: zero wait states, read data registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Decoding in the setup cycle lets prdata stand through the whole access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        ADDR_W'(`SCC_CTRL_ADDR): begin
          prdata <= {24'h00_0000, ctrl};
        end
        ADDR_W'(`SCC_STAT_ADDR): begin
          prdata <= {28'h000_0000, in_stop, cpu_clock_stall, sw_state != SCC_SW_IDLE,
                     applied_src};
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule // scc_clock_ctrl

// file: rtl/scc_fb_div.sv
// Feedback divider: a free counter whose tap is picked by the speed select.
`timescale 1ns/100ps
`include "scc_params.svh"
module scc_fb_div
  import scc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic vco_tick,
  input wire logic run,
  input wire logic [1:0] speed_sel,
  output logic fb_clk
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (vco_tick) begin
      count <= count + 1'b1;
    end
  end

  // Speed 00 divides by 256, 11 by 32: tap bit 7 down to bit 4.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_clk <= 1'b0;
    end else begin
      fb_clk <= count[3'(7 - int'(speed_sel))];
    end
  end
endmodule // scc_fb_div

// file: rtl/scc_sync.sv
// Two-flop synchroniser for a level from another clock domain.
`timescale 1ns/100ps
module scc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // scc_sync
